// *** verilog/cidc_defines.svh ***
/*
  constants for the console idle/display control block.
  assumes a 12-bit machine word and a three-point machine cycle.
*/
`ifndef CIDC_DEFINES_SVH
`define CIDC_DEFINES_SVH
`define CIDC_WORD_W 12
`define CIDC_SET_W 15
`define CIDC_OP_W 6
`define CIDC_ZERO_WORD 12'h000
`define CIDC_ZERO_SET 15'h0000
`define CIDC_ZERO_OP 6'h00
`endif

// *** verilog/cidc_pkg.sv ***
/*
  types for the console idle/display control block.
  assumes cidc_defines.svh is on the include path.
*/
`include "cidc_defines.svh"
package cidc_pkg;
  typedef enum logic [1:0] {CIDC_T1, CIDC_T0, CIDC_TP} cidc_tp_t;
  typedef struct packed {
    logic reset_btn;
    logic parity_err;
    logic run_to_idle;
    logic prog_halt;
    logic instr_end;
    logic temp_ok;
  } cidc_evt_t;
  typedef struct packed {
    logic run_switch;
    logic step_switch;
    logic mem_in;
    logic mem_out;
    logic loc_inc;
    logic pick_b_switch;
    logic pick_c_switch;
    logic target_p;
    logic clear_btn;
    logic [`CIDC_SET_W-1:0] set_buttons;
  } cidc_con_t;
  typedef struct packed {
    cidc_tp_t tp;
    logic idle;
    logic halt_request;
    logic idle_subphase_flag;
    logic display_a_select;
    logic parity_halt_flag;
    logic display_sync_flag;
    logic swap_flag;
    logic execute_hold_flag;
    logic last_step_flag;
    logic [`CIDC_OP_W-1:0] opcode;
    logic [`CIDC_WORD_W-1:0] reg_a;
    logic [`CIDC_WORD_W-1:0] reg_b;
    logic [`CIDC_WORD_W-1:0] reg_c;
    logic [`CIDC_SET_W-1:0] reg_p;
    logic [`CIDC_SET_W-1:0] mem_addr;
    logic [`CIDC_WORD_W-1:0] display;
    logic [`CIDC_SET_W-1:0] loc_lights;
    logic mem_start;
    logic parity_light;
    logic halt_light;
    logic console_exec;
  } cidc_state_t;
endpackage : cidc_pkg

// *** verilog/cidc_core.sv ***
/*
  idle phase, interlock, register display/alteration, console hand-off.
  assumes synchronous console inputs and a single clock.
*/
`timescale 1ns/1ns
`include "cidc_defines.svh"
//////////////////////////////////////////////////////////////////////////////
module cidc_core
  import cidc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire cidc_evt_t evt,
  input wire cidc_con_t con,
  output logic idle,
  output logic halt_request,
  output logic idle_subphase_flag,
  output logic swap_flag,
  output logic display_sync_flag,
  output logic display_a_select,
  output logic [`CIDC_WORD_W-1:0] display,
  output logic [`CIDC_SET_W-1:0] loc_lights,
  output logic [`CIDC_SET_W-1:0] mem_addr,
  output logic mem_start,
  output logic parity_light,
  output logic halt_light,
  output logic console_exec
);

  cidc_state_t s;
  cidc_state_t next_s;
  logic [`CIDC_WORD_W-1:0] adder_bus;
  logic any_func;
  logic interlock;
  logic disp_sub;

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [`CIDC_WORD_W-1:0] set_buttons_low;
    logic [`CIDC_WORD_W-1:0] reg_sel;
    logic set_buttons_high_any;
    set_buttons_low = con.set_buttons[`CIDC_WORD_W-1:0];
    set_buttons_high_any = |con.set_buttons[`CIDC_SET_W-1:`CIDC_WORD_W];
    any_func = con.run_switch | con.step_switch | con.mem_in |
               con.mem_out | con.loc_inc;
    interlock = s.idle & ~s.idle_subphase_flag & s.halt_request;
    disp_sub = s.idle & s.idle_subphase_flag & s.halt_request;
    reg_sel = s.display_a_select ? s.reg_a : s.reg_c;
    adder_bus = reg_sel;
    if (disp_sub && !con.target_p) begin
      // high set buttons have no bus bit; only the low twelve reach it
      if (con.clear_btn) begin
        adder_bus = `CIDC_ZERO_WORD;
      end
      if (s.tp == CIDC_TP) begin
        adder_bus = adder_bus | set_buttons_low;
      end
    end
    if (interlock) begin
      adder_bus = s.reg_c;
    end
    next_s = s;
    next_s.console_exec = 1'b0;
    unique case (s.tp)
      CIDC_T1: next_s.tp = CIDC_T0;
      CIDC_T0: next_s.tp = CIDC_TP;
      CIDC_TP: next_s.tp = CIDC_T1;
    endcase
    if (evt.parity_err) begin
      next_s.parity_halt_flag = 1'b1;
    end
    // halt request raised; idle entered at instruction end
    if (!s.idle && (evt.run_to_idle || evt.prog_halt ||
        con.step_switch)) begin
      next_s.halt_request = 1'b1;
    end
    if (!s.idle && s.halt_request && evt.instr_end && s.tp == CIDC_TP) begin
      next_s.idle = 1'b1;
      next_s.idle_subphase_flag = 1'b0;
    end
    if (interlock) begin
      next_s.opcode = `CIDC_ZERO_OP;
      next_s.swap_flag = 1'b0;
      if (!s.display_sync_flag) begin
        next_s.display_sync_flag = 1'b1;
      end
      next_s.display_a_select = 1'b0;
      next_s.execute_hold_flag = 1'b0;
      next_s.last_step_flag = 1'b0;
      if (s.tp == CIDC_TP && !s.parity_halt_flag && !any_func &&
          !evt.reset_btn) begin
        next_s.idle_subphase_flag = 1'b1;
      end
    end
    if (disp_sub) begin
      next_s.display_a_select = ~con.pick_c_switch;
      next_s.execute_hold_flag = 1'b0;
      next_s.last_step_flag = 1'b0;
      next_s.mem_addr = s.reg_p;
      if (!con.target_p) begin
        if (s.display_a_select) begin
          next_s.reg_a = adder_bus;
        end else begin
          next_s.reg_c = adder_bus;
        end
      end else begin
        next_s.reg_p = (con.clear_btn ? `CIDC_ZERO_SET : s.reg_p) |
                       (s.tp == CIDC_TP ? con.set_buttons : `CIDC_ZERO_SET);
      end
      if (s.tp == CIDC_T1 && (con.pick_b_switch ^ s.swap_flag)) begin
        next_s.display_sync_flag = 1'b0;
      end
      if (s.tp == CIDC_T0 && !s.display_sync_flag) begin
        // swap wins over the bus write-back in this cycle
        next_s.reg_a = s.reg_b;
        next_s.reg_b = s.reg_a;
        next_s.swap_flag = ~s.swap_flag;
        next_s.display_sync_flag = 1'b1;
      end
      if (s.tp == CIDC_TP && evt.temp_ok && any_func) begin
        next_s.halt_request = 1'b0;
        next_s.console_exec = 1'b1;
        // run and step leave idle; the others come back to display
        if (con.run_switch || con.step_switch) begin
          next_s.idle = 1'b0;
        end
      end
    end
    // memory and location functions return to display one cycle on
    if (s.idle && s.idle_subphase_flag && !s.halt_request) begin
      next_s.halt_request = 1'b1;
    end
    // immediate idle wins over the idle, halt request and subphase updates above
    if (evt.reset_btn || evt.parity_err) begin
      next_s.idle = 1'b1;
      next_s.halt_request = 1'b1;
      next_s.idle_subphase_flag = 1'b0;
    end
    next_s.display = adder_bus;
    next_s.loc_lights = next_s.reg_p;
    next_s.mem_start = ~evt.reset_btn & evt.temp_ok;
    next_s.parity_light = next_s.parity_halt_flag;
    next_s.halt_light = next_s.parity_halt_flag;
  end

  //////////////////////////////////////////////////////////////////////////
  // one edge for all flags; rising edge stands in for the falling one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.idle <= 1'b1;
      s.halt_request <= 1'b1;
      s.display_sync_flag <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign idle = s.idle;
  assign halt_request = s.halt_request;
  assign idle_subphase_flag = s.idle_subphase_flag;
  assign swap_flag = s.swap_flag;
  assign display_sync_flag = s.display_sync_flag;
  assign display_a_select = s.display_a_select;
  assign display = s.display;
  assign loc_lights = s.loc_lights;
  assign mem_addr = s.mem_addr;
  assign mem_start = s.mem_start;
  assign parity_light = s.parity_light;
  assign halt_light = s.halt_light;
  assign console_exec = s.console_exec;

  //////////////////////////////////////////////////////////////////////////
  reset_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    evt.reset_btn |=> idle && !idle_subphase_flag)
    else $error("reset did not force interlock idle");
  parity_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    evt.parity_err |=> idle && halt_light && parity_light)
    else $error("parity halt did not force idle");
  mem_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (evt.reset_btn || !evt.temp_ok) |=> !mem_start)
    else $error("memory start not suppressed");
  interlock_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
    (interlock && s.tp == CIDC_TP && !s.parity_halt_flag && !any_func &&
     !evt.reset_btn && !evt.parity_err) |=> idle_subphase_flag)
    else $error("interlock exit missed");
  interlock_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
    interlock && !evt.reset_btn |=> !swap_flag && display_sync_flag
    && s.opcode == `CIDC_ZERO_OP)
    else $error("interlock did not clear state");
  sync_swap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (disp_sub && s.tp == CIDC_T0 && !display_sync_flag && !evt.reset_btn
     && !evt.parity_err) |=> display_sync_flag &&
     swap_flag != $past(swap_flag) && s.reg_a == $past(s.reg_b))
    else $error("display swap not done");
  sync_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (disp_sub && s.tp == CIDC_T1 && (con.pick_b_switch ^ swap_flag) &&
     !evt.reset_btn && !evt.parity_err) |=> !display_sync_flag)
    else $error("sync flag not cleared");
  select_a: assert property (@(posedge clk) disable iff (!rst_n)
    disp_sub && !evt.reset_btn && !evt.parity_err
    |=> display_a_select == !$past(con.pick_c_switch))
    else $error("display select wrong");
  addr_copy_a: assert property (@(posedge clk) disable iff (!rst_n)
    disp_sub |=> mem_addr == $past(s.reg_p))
    else $error("address not copied from P");
  exec_go_a: assert property (@(posedge clk) disable iff (!rst_n)
    (disp_sub && s.tp == CIDC_TP && evt.temp_ok && any_func &&
     !evt.reset_btn && !evt.parity_err) |=> !halt_request && console_exec)
    else $error("console function not started");
  clear_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (disp_sub && !con.target_p && con.clear_btn && s.tp != CIDC_TP &&
     !display_a_select) |=> s.reg_c == `CIDC_ZERO_WORD)
    else $error("clear did not zero register");

endmodule : cidc_core

// *** tb/cidc_console.sv ***
/*
  operator console model: function switches, select switches and buttons.
  assumes the bench calls put() to move switches, one change per edge.
*/
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module cidc_console
  import cidc_pkg::*;
(
  input wire logic clk,
  output cidc_con_t con
);
  initial con = '0;
  // clean single levels: a switch pair never bounces both ways
  task automatic put(input cidc_con_t v);
    @(posedge clk);
    #10;
    con = v;
  endtask : put
endmodule : cidc_console

// *** tb/console_idle_display_control_tb.sv ***
/*
  self-checking bench for the idle/display control core.
  assumes the timing point counter starts at T1 after reset release.
*/
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module console_idle_display_control_tb
  import cidc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  cidc_evt_t evt = '0;
  cidc_con_t c = '0;
  cidc_con_t con;
  logic idle, halt_request, idle_subphase_flag, swap_flag;
  logic display_sync_flag, display_a_select, mem_start;
  logic parity_light, halt_light, console_exec;
  logic [11:0] display;
  logic [14:0] loc_lights, mem_addr;
  int err_count = 0;
  int compares = 0;
  int ex_cnt = 0;
  int n;
  always #50 clk = ~clk;
  // sampled on the far edge to stay clear of the update edge
  always @(negedge clk) if (console_exec === 1'b1) ex_cnt++;
  cidc_console con_u (.clk(clk), .con(con));
  cidc_core dut_u (.clk(clk), .rst_n(rst_n), .evt(evt), .con(con),
    .idle(idle), .halt_request(halt_request),
    .idle_subphase_flag(idle_subphase_flag), .swap_flag(swap_flag),
    .display_sync_flag(display_sync_flag),
    .display_a_select(display_a_select), .display(display),
    .loc_lights(loc_lights), .mem_addr(mem_addr), .mem_start(mem_start),
    .parity_light(parity_light), .halt_light(halt_light),
    .console_exec(console_exec));
//////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [14:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #10;
  endtask : cyc
  task automatic put_set(input logic [14:0] v);
    c.set_buttons = v;
    con_u.put(c);
    cyc(4);
    c.set_buttons = '0;
    con_u.put(c);
    cyc(4);
  endtask : put_set
  task automatic to_display();
    for (int i = 0; i < 9 && idle_subphase_flag !== 1'b1; i++) cyc(1);
    check("subphase", 15'(idle_subphase_flag), 15'h0001);
  endtask : to_display
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    print_verdict();
  end
//////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    #10;
    check("idle", 15'(idle), 15'h0001);
    check("halt", 15'(halt_request), 15'h0001);
    check("mstart", 15'(mem_start), 15'h0000);
    rst_n = 1'b1;
    c.step_switch = 1'b1;
    con_u.put(c);
    cyc(6);
    check("locked", 15'(idle_subphase_flag), 15'h0000);
    check("cold", 15'(mem_start), 15'h0000);
    c.step_switch = 1'b0;
    con_u.put(c);
    to_display();
    $display("test interlock done");
    c.pick_c_switch = 1'b1;
    c.clear_btn = 1'b1;
    con_u.put(c);
    cyc(4);
    check("sel_c", 15'(display_a_select), 15'h0000);
    check("clr_c", 15'(display), 15'h0000);
    c.clear_btn = 1'b0;
    put_set(15'h00a5);
    check("set_c", 15'(display), 15'h00a5);
    c.target_p = 1'b1;
    put_set(15'h5a3c);
    check("p_set", loc_lights, 15'h5a3c);
    check("p_addr", mem_addr, 15'h5a3c);
    check("c_kept", 15'(display), 15'h00a5);
    $display("test c and p done");
    c.target_p = 1'b0;
    c.pick_c_switch = 1'b0;
    put_set(15'h0123);
    check("sel_a", 15'(display_a_select), 15'h0001);
    check("set_a", 15'(display), 15'h0123);
    c.pick_b_switch = 1'b1;
    con_u.put(c);
    cyc(6);
    check("swap", 15'(swap_flag), 15'h0001);
    check("sync", 15'(display_sync_flag), 15'h0001);
    check("show_b", 15'(display), 15'h0000);
    put_set(15'h0456);
    check("set_b", 15'(display), 15'h0456);
    c.pick_b_switch = 1'b0;
    con_u.put(c);
    cyc(6);
    check("home", 15'(swap_flag), 15'h0000);
    check("show_a", 15'(display), 15'h0123);
    $display("test a and b done");
    c.run_switch = 1'b1;
    con_u.put(c);
    cyc(6);
    check("cold_go", 15'(ex_cnt), 15'h0000);
    check("cold_ht", 15'(halt_request), 15'h0001);
    c.run_switch = 1'b0;
    con_u.put(c);
    // kinds: step, run to idle, halt, reset button, parity error
    for (int k = 0; k < 5; k++) begin
      n = ex_cnt;
      evt.temp_ok = 1'b1;
      to_display();
      c.step_switch = (k == 0);
      c.run_switch = (k != 0);
      con_u.put(c);
      cyc(5);
      check("handoff", 15'(ex_cnt - n), 15'h0001);
      evt.run_to_idle = (k == 1);
      evt.prog_halt = (k == 2);
      evt.reset_btn = (k == 3);
      evt.parity_err = (k == 4);
      cyc(1);
      evt.run_to_idle = 1'b0;
      evt.prog_halt = 1'b0;
      cyc(3);
      if (k < 3) begin
        check("ht_up", 15'(halt_request), 15'h0001);
        check("wait_end", 15'(idle), 15'h0000);
        evt.instr_end = 1'b1;
        cyc(4);
        evt.instr_end = 1'b0;
      end
      check("to_idle", 15'(idle), 15'h0001);
      check("lk_swap", 15'(swap_flag), 15'h0000);
      check("lk_sel", 15'(display_a_select), 15'h0000);
      if (k == 3) check("rst_ms", 15'(mem_start), 15'h0000);
      c.step_switch = 1'b0;
      c.run_switch = 1'b0;
      con_u.put(c);
      evt.reset_btn = 1'b0;
    end
    check("par_lt", 15'(parity_light), 15'h0001);
    check("halt_lt", 15'(halt_light), 15'h0001);
    $display("test hand-off and idle entry done");
    print_verdict();
  end
endmodule : console_idle_display_control_tb
